/* File: logic/acc_adc_ctrl.sv */
// Purpose: Register file, clocking and sequencing of a 10/8-bit converter
// Assumes: AXI4-Lite slave; analog comparator drives cmp_in each bit step
// Notes:   Async source arrives as a synchronous tick enable
//
// Design decisions made here: the AXI4-Lite interface to the registers and the register addresses.
`timescale 1ns/1ps
`include "acc_defines.svh"
module acc_adc_ctrl
  import acc_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic        ce,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [3:0]  s_axi_awaddr,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [3:0]  s_axi_araddr,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  input  wire logic        bus4_tick,
  input  wire logic        async_tick,
  input  wire logic        stop_mode,
  input  wire logic        cmp_in,
  output acc_mux_t         mux_out,
  output logic [9:0]       dac_code,
  output logic             port_b_bit_zero_sel,
  output logic             port_b_bit_one_sel,
  output logic             bandgap_sel
);
  // ----------------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------------
  logic [4:0]  channel_select_field;
  logic        cont_mode, done;
  logic [7:0]  conv_clock_reg, result_low;
  logic [1:0]  result_high_reg;
  acc_state_t  state;
  logic [3:0]  step, aw_addr, w_strb, nbits, samp_len;
  logic [9:0]  sar;
  logic [31:0] w_data;
  logic        aw_hold, w_hold, start_req;
  logic        ref_tick, conv_tick, run_ok, wr_go, wr_scr;

  // ----------------------------------------------------------------------
  // Clock selection and divider
  // ----------------------------------------------------------------------
  // Async source or bus-times-four source
  assign ref_tick = conv_clock_reg[`ACC_CLK_ACLK] ? async_tick
                  : bus4_tick;
  // Stop mode halts only the bus-derived clock path
  assign run_ok = !stop_mode || conv_clock_reg[`ACC_CLK_ACLK];

  acc_clkdiv u_div
  (
    .aclk      (aclk),
    .aresetn   (aresetn),
    .ce        (ce && run_ok),
    .ref_tick  (ref_tick),
    .div_sel   (conv_clock_reg[6:5]),
    .conv_tick (conv_tick)
  );

  // Bit count and sample length
  assign nbits = conv_clock_reg[`ACC_CLK_MODE] ? `ACC_BITS10
               : `ACC_BITS8;
  assign samp_len = conv_clock_reg[`ACC_CLK_LSMP] ? `ACC_SAMP_LONG
                  : `ACC_SAMP_SHORT;

  // ----------------------------------------------------------------------
  // Channel decode
  // ----------------------------------------------------------------------
  // Select lines only; pin digital drivers are untouched
  always_comb
  begin
    port_b_bit_zero_sel = (channel_select_field == `ACC_CH_PORT_B_BIT_ZERO);
    port_b_bit_one_sel  = (channel_select_field == `ACC_CH_PORT_B_BIT_ONE);
    bandgap_sel         = (channel_select_field == `ACC_CH_BGAP);
    mux_out.chan        = channel_select_field;
    mux_out.sample      = (state == ACC_SAMPLE);
    mux_out.pin_sel     = (channel_select_field < `ACC_CH_PINS);
  end

  // ----------------------------------------------------------------------
  // AXI4-Lite write path
  // ----------------------------------------------------------------------
  assign s_axi_awready = !aw_hold && !s_axi_bvalid;
  assign s_axi_wready  = !w_hold && !s_axi_bvalid;
  assign s_axi_bresp   = 2'b00;
  assign wr_go = aw_hold && w_hold && !s_axi_bvalid;
  assign wr_scr = wr_go && w_strb[0] && (aw_addr == `ACC_OFS_SCR);
  // Capture address and data in either order
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_hold      <= 1'b0;
      w_hold       <= 1'b0;
      aw_addr      <= 4'h0;
      w_data       <= 32'h0;
      w_strb       <= 4'h0;
      s_axi_bvalid <= 1'b0;
    end
    else if (ce)
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (wr_go)
      begin
        aw_hold      <= 1'b0;
        w_hold       <= 1'b0;
        s_axi_bvalid <= 1'b1;
      end
      else if (s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end
  // Control registers written by software
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      channel_select_field <= `ACC_CH_RESET;
      cont_mode            <= 1'b0;
      conv_clock_reg       <= `ACC_CLK_RESET;
      start_req            <= 1'b0;
    end
    else if (ce)
    begin
      start_req <= 1'b0;
      if (wr_go && w_strb[0])
      begin
        if (aw_addr == `ACC_OFS_SCR)
        begin
          channel_select_field <= w_data[4:0];
          cont_mode            <= w_data[`ACC_SCR_CONT];
          start_req            <= (w_data[4:0] != `ACC_CH_OFF);
        end
        if (aw_addr == `ACC_OFS_CLK)
        begin
          conv_clock_reg <= {1'b0, w_data[6:1], 1'b0};
        end
      end
    end
  end
  // ----------------------------------------------------------------------
  // Conversion sequencer
  // ----------------------------------------------------------------------
  // Trial code set one tick ahead so the comparator has settled
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      state           <= ACC_IDLE;
      step            <= 4'h0;
      sar             <= 10'h000;
      done            <= 1'b0;
      result_high_reg <= 2'b00;
      result_low      <= 8'h00;
      dac_code        <= 10'h000;
    end
    else if (ce)
    begin
      if (wr_scr)
      begin
        done     <= 1'b0;
        state    <= ACC_IDLE;
        dac_code <= 10'h000;
      end
      else if (start_req)
      begin
        state    <= ACC_SAMPLE;
        step     <= 4'h0;
        dac_code <= 10'h000;
      end
      else if (conv_tick && run_ok)
      begin
        case (state)
          ACC_SAMPLE:
          begin
            if (step >= samp_len)
            begin
              state    <= ACC_CONV;
              step     <= 4'h0;
              sar      <= 10'h000;
              dac_code <= `ACC_TRIAL_MSB;
            end
            else
            begin
              step <= step + 4'h1;
            end
          end
          ACC_CONV:
          begin
            sar[9 - step] <= cmp_in;
            if (step == nbits - 4'h1)
            begin
              done     <= 1'b1;
              dac_code <= 10'h000;
              if (nbits == `ACC_BITS10)
              begin
                result_high_reg <= sar[9:8];
                result_low      <= {sar[7:1], cmp_in};
              end
              else
              begin
                result_high_reg <= 2'b00;
                result_low      <= {sar[9:3], cmp_in};
              end
              state <= cont_mode ? ACC_SAMPLE : ACC_IDLE;
              step  <= 4'h0;
            end
            else
            begin
              dac_code <= (cmp_in ? dac_code
                           : dac_code & ~(`ACC_TRIAL_MSB >> step))
                          | (`ACC_TRIAL_MSB >> (step + 4'h1));
              step     <= step + 4'h1;
            end
          end
          default:
          begin
            state    <= ACC_IDLE;
            dac_code <= 10'h000;
          end
        endcase
      end
    end
  end
  // ----------------------------------------------------------------------
  // AXI4-Lite read path
  // ----------------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;
  assign s_axi_rresp   = 2'b00;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0;
    end
    else if (ce)
    begin
      if (s_axi_arvalid && s_axi_arready)
      begin
        s_axi_rvalid <= 1'b1;
        case (s_axi_araddr)
          `ACC_OFS_SCR:  s_axi_rdata <= {24'h0, done, 1'b0, cont_mode,
                                         channel_select_field};
          `ACC_OFS_RESH: s_axi_rdata <= {30'h0, result_high_reg};
          `ACC_OFS_RESL: s_axi_rdata <= {24'h0, result_low};
          `ACC_OFS_CLK:  s_axi_rdata <= {24'h0, conv_clock_reg};
          default:       s_axi_rdata <= 32'h0;
        endcase
      end
      else if (s_axi_rready)
      begin
        s_axi_rvalid <= 1'b0;
      end
    end
  end
endmodule : acc_adc_ctrl

/* File: logic/acc_defines.svh */
// Purpose: Named offsets, fields, resets and counts for the converter control
// Assumes: Included by its bare name
// Notes:   Definitions only
`ifndef ACC_DEFINES_SVH
`define ACC_DEFINES_SVH
// ----------------------------------------------------------------------
// Register byte addresses
// ----------------------------------------------------------------------
`define ACC_OFS_SCR     4'h0
`define ACC_OFS_RESH    4'h4
`define ACC_OFS_RESL    4'h8
`define ACC_OFS_CLK     4'hC
// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define ACC_SCR_DONE    7
`define ACC_SCR_CONT    5
`define ACC_CLK_LSMP    4
`define ACC_CLK_MODE    3
`define ACC_CLK_ACLK    2
`define ACC_CLK_RSEL    1
// ----------------------------------------------------------------------
// Reset values and channel codes
// ----------------------------------------------------------------------
`define ACC_CH_RESET    5'h1F
`define ACC_CLK_RESET   8'h00
`define ACC_CH_PORT_B_BIT_ZERO     5'h04
`define ACC_CH_PORT_B_BIT_ONE     5'h05
`define ACC_CH_BGAP     5'h1A
`define ACC_CH_OFF      5'h1F
`define ACC_CH_PINS     5'h06
// ----------------------------------------------------------------------
// Timing counts in conversion clock cycles, reference multiple and first trial code
// ----------------------------------------------------------------------
`define ACC_SAMP_SHORT  4'h3
`define ACC_SAMP_LONG   4'hF
`define ACC_BITS10      4'hA
`define ACC_BITS8       4'h8
`define ACC_REFMUL      4'h4
`define ACC_TRIAL_MSB   10'h200
`endif

/* File: logic/acc_pkg.sv */
// Purpose: Types for the converter control
// Assumes: acc_defines.svh holds the numbers
// Notes:   Types only
package acc_pkg;
  typedef enum logic [1:0]
  {
    ACC_IDLE   = 2'b00,
    ACC_SAMPLE = 2'b01,
    ACC_CONV   = 2'b10
  } acc_state_t;

  typedef struct packed
  {
    logic [4:0] chan;
    logic       sample;
    logic       pin_sel;
  } acc_mux_t;
endpackage : acc_pkg

/* File: logic/acc_clkdiv.sv */
// Purpose: Conversion clock enable from a reference enable and divider
// Assumes: Reference enable is a one-cycle pulse per reference tick
// Notes:   Divider of 1, 2, 4 or 8 reference ticks
`timescale 1ns/1ps
module acc_clkdiv
  import acc_pkg::*;
(
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic       ce,
  input  wire logic       ref_tick,
  input  wire logic [1:0] div_sel,
  output logic            conv_tick
);
  logic [2:0] cnt;
  logic [2:0] lim;

  // Terminal count for the chosen division
  always_comb
  begin
    lim = 3'((4'h1 << div_sel) - 4'h1);
  end

  // Count reference ticks, pulse at terminal count
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      cnt       <= 3'h0;
      conv_tick <= 1'b0;
    end
    else if (ce)
    begin
      conv_tick <= 1'b0;
      if (ref_tick)
      begin
        if (cnt >= lim)
        begin
          cnt       <= 3'h0;
          conv_tick <= 1'b1;
        end
        else
        begin
          cnt <= cnt + 3'h1;
        end
      end
    end
  end
endmodule : acc_clkdiv

/* File: tb/acc_adc_ctrl_sva.sv */
// Purpose: Port checks for the converter control
// Assumes: One clock; reset synchronous, active low
// Notes:   Bound to acc_adc_ctrl below
`timescale 1ns/1ps
`include "acc_defines.svh"
module acc_adc_ctrl_sva
(
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [3:0]  s_axi_awaddr,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [3:0]  s_axi_araddr,
  input wire logic        s_axi_rvalid,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        stop_mode,
  input wire logic [9:0]  dac_code,
  input wire logic        port_b_bit_zero_sel,
  input wire logic        port_b_bit_one_sel,
  input wire logic        bandgap_sel
);
  logic wr;
  logic mode10;
  logic aen;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  assign wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  // Shadow of mode and async enable from clock register writes
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      mode10 <= 1'b0;
      aen    <= 1'b0;
    end
    else if (wr && s_axi_awaddr == `ACC_OFS_CLK && s_axi_wvalid)
    begin
      mode10 <= s_axi_wdata[`ACC_CLK_MODE];
      aen    <= s_axi_wdata[`ACC_CLK_ACLK];
    end
  end
  property p_sel_zero;
    wr && s_axi_awaddr == `ACC_OFS_SCR && s_axi_wdata[4:0] == 5'h04
      |-> ##[1:2] port_b_bit_zero_sel && !port_b_bit_one_sel;
  endproperty
  a_sel_zero: assert property (p_sel_zero)
    else $error("Port B bit zero not selected");
  property p_sel_one;
    wr && s_axi_awaddr == `ACC_OFS_SCR && s_axi_wdata[4:0] == 5'h05
      |-> ##[1:2] port_b_bit_one_sel && !port_b_bit_zero_sel;
  endproperty
  a_sel_one: assert property (p_sel_one)
    else $error("Port B bit one not selected");
  property p_bgap;
    wr && s_axi_awaddr == `ACC_OFS_SCR && s_axi_wdata[4:0] == 5'h1A
      |-> ##[1:2] bandgap_sel && !port_b_bit_zero_sel;
  endproperty
  a_bgap: assert property (p_bgap)
    else $error("Bandgap not selected");
  property p_resh;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == `ACC_OFS_RESH
      |=> s_axi_rdata[31:2] == 30'h0 && (mode10 || s_axi_rdata[1:0] == 2'h0);
  endproperty
  a_resh: assert property (p_resh)
    else $error("High result word has stray bits");
  property p_resl;
    s_axi_arvalid && s_axi_arready && s_axi_araddr == `ACC_OFS_RESL
      |=> s_axi_rvalid && s_axi_rdata[31:8] == 24'h0;
  endproperty
  a_resl: assert property (p_resl)
    else $error("Low result word wider than a byte");
  property p_stop;
    stop_mode && !aen && !s_axi_awvalid && !$past(s_axi_awvalid)
      && !$past(s_axi_awvalid, 2) && !$past(s_axi_awvalid, 3)
      |=> $stable(dac_code);
  endproperty
  a_stop: assert property (p_stop)
    else $error("Conversion moved in stop without async clock");
  property p_rd_lat;
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
  endproperty
  a_rd_lat: assert property (p_rd_lat)
    else $error("Read data late");
  property p_b_lat;
    wr |-> ##[1:2] s_axi_bvalid;
  endproperty
  a_b_lat: assert property (p_b_lat)
    else $error("Write response late");
  property p_b_refuse;
    s_axi_bvalid |-> !s_axi_awready && !s_axi_wready;
  endproperty
  a_b_refuse: assert property (p_b_refuse)
    else $error("Write taken while response pending");
endmodule : acc_adc_ctrl_sva
bind acc_adc_ctrl acc_adc_ctrl_sva acc_adc_ctrl_sva_inst
(
  .aclk                (aclk),
  .aresetn             (aresetn),
  .s_axi_awvalid       (s_axi_awvalid),
  .s_axi_awready       (s_axi_awready),
  .s_axi_awaddr        (s_axi_awaddr),
  .s_axi_wvalid        (s_axi_wvalid),
  .s_axi_wready        (s_axi_wready),
  .s_axi_wdata         (s_axi_wdata),
  .s_axi_bvalid        (s_axi_bvalid),
  .s_axi_arvalid       (s_axi_arvalid),
  .s_axi_arready       (s_axi_arready),
  .s_axi_araddr        (s_axi_araddr),
  .s_axi_rvalid        (s_axi_rvalid),
  .s_axi_rdata         (s_axi_rdata),
  .stop_mode           (stop_mode),
  .dac_code            (dac_code),
  .port_b_bit_zero_sel (port_b_bit_zero_sel),
  .port_b_bit_one_sel  (port_b_bit_one_sel),
  .bandgap_sel         (bandgap_sel)
);

/* File: tb/acc_afe_model.sv */
// Purpose: Analog front end: channel mux and comparator
// Assumes: Pins set as inputs by software, levels come from the bench
// Notes:   Bandgap level is a plain default
`timescale 1ns/1ps
`include "acc_defines.svh"
module acc_afe_model
  import acc_pkg::*;
#(
  parameter logic [9:0] BG_LEVEL = 10'h1C3
)
(
  input  wire logic [9:0] dac_code,
  input  wire acc_mux_t   mux_out,
  input  wire logic [9:0] vin,
  output logic            cmp_in
);
  logic [9:0] level;
  // Pin level as input, or bandgap when chosen
  assign level = (mux_out.chan == `ACC_CH_BGAP) ? BG_LEVEL : vin;
  // Comparator high while input at or above trial code
  assign cmp_in = (level >= dac_code);
endmodule : acc_afe_model

/* File: tb/tb_adc_control_and_clocking.sv */
// Purpose: Self-checking bench for the converter control
// Assumes: Divider at one or two, bus tick every cycle, async every other
// Notes:   Random levels from a fixed-seed shift register
`timescale 1ns/1ps
`include "acc_defines.svh"
module tb_adc_control_and_clocking
  import acc_pkg::*;
;
  logic        aclk = 1'b0;
  logic        aresetn, ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready;
  logic        s_axi_arvalid, s_axi_rready, bus4_tick, async_tick, stop_mode;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready;
  logic        s_axi_rvalid, cmp_in, port_b_bit_zero_sel, port_b_bit_one_sel;
  logic        bandgap_sel, m10, cont_bit;
  logic [3:0]  s_axi_awaddr, s_axi_araddr, s_axi_wstrb;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd, lfsr;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [9:0]  dac_code, vin, res;
  logic [4:0]  codes [5] = '{5'h04, 5'h05, 5'h1A, 5'h00, 5'h1F};
  acc_mux_t    mux_out;
  int          num_errors, check_count, t0, t1;
  acc_adc_ctrl acc_adc_ctrl_inst
  (
    .aclk                (aclk),
    .aresetn             (aresetn),
    .ce                  (ce),
    .s_axi_awvalid       (s_axi_awvalid),
    .s_axi_awready       (s_axi_awready),
    .s_axi_awaddr        (s_axi_awaddr),
    .s_axi_wvalid        (s_axi_wvalid),
    .s_axi_wready        (s_axi_wready),
    .s_axi_wdata         (s_axi_wdata),
    .s_axi_wstrb         (s_axi_wstrb),
    .s_axi_bvalid        (s_axi_bvalid),
    .s_axi_bready        (s_axi_bready),
    .s_axi_bresp         (s_axi_bresp),
    .s_axi_arvalid       (s_axi_arvalid),
    .s_axi_arready       (s_axi_arready),
    .s_axi_araddr        (s_axi_araddr),
    .s_axi_rvalid        (s_axi_rvalid),
    .s_axi_rready        (s_axi_rready),
    .s_axi_rdata         (s_axi_rdata),
    .s_axi_rresp         (s_axi_rresp),
    .bus4_tick           (bus4_tick),
    .async_tick          (async_tick),
    .stop_mode           (stop_mode),
    .cmp_in              (cmp_in),
    .mux_out             (mux_out),
    .dac_code            (dac_code),
    .port_b_bit_zero_sel (port_b_bit_zero_sel),
    .port_b_bit_one_sel  (port_b_bit_one_sel),
    .bandgap_sel         (bandgap_sel)
  );
  acc_afe_model #(.BG_LEVEL(10'h1C3)) acc_afe_model_inst
  (
    .dac_code (dac_code),
    .mux_out  (mux_out),
    .vin      (vin),
    .cmp_in   (cmp_in)
  );
  // Clock and async reference tick
  always #12.5 aclk = ~aclk;
  always @(posedge aclk) async_tick <= !async_tick;
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr_next
  // Expected code: whole level in 10-bit mode, top eight bits otherwise
  function automatic logic [9:0] exp_res(input logic [9:0] v,
                                         input logic       m);
    return m ? v : {2'h0, v[9:2]};
  endfunction : exp_res
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      num_errors++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  task automatic axi_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge aclk);
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
    end while (!s_axi_bvalid);
    s_axi_bready <= 1'b0;
  endtask : axi_wr
  task automatic axi_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge aclk);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(posedge aclk);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
    end while (!s_axi_rvalid);
    d = s_axi_rdata;
    s_axi_rready <= 1'b0;
  endtask : axi_rd
  // Start, poll done, read both result words; returns cycles taken
  task automatic convert(input logic [4:0] ch, output int cyc);
    logic [31:0] d;
    axi_wr(`ACC_OFS_SCR, {26'h0, cont_bit, ch});
    cyc = int'($time / 25);
    do axi_rd(`ACC_OFS_SCR, d);
    while (!d[`ACC_SCR_DONE]);
    cyc = int'($time / 25) - cyc;
    axi_rd(`ACC_OFS_RESH, d);
    res[9:8] = d[1:0];
    axi_rd(`ACC_OFS_RESL, d);
    res[7:0] = d[7:0];
  endtask : convert
  task automatic summarize();
    $display("Checks %0d, errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize
  // Watchdog
  initial
  begin
    repeat (30000) @(posedge aclk);
    num_errors++;
    $display("MISMATCH t=%0t watchdog expired", $time);
    summarize();
  end
  // Main sequence
  initial
  begin
    {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
    {s_axi_arvalid, s_axi_rready, async_tick, stop_mode} = 4'h0;
    {ce, bus4_tick, s_axi_wstrb} = 6'h3F;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, vin} = '0;
    lfsr = 32'h00017F46;
    cont_bit = 1'b0;
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    axi_rd(`ACC_OFS_SCR, rd);
    chk(rd, 32'h0000001F);
    axi_rd(`ACC_OFS_CLK, rd);
    chk(rd, 32'h00000000);
    foreach (codes[i])
    begin
      axi_wr(`ACC_OFS_SCR, {27'h0, codes[i]});
      chk({mux_out.chan, mux_out.pin_sel, bandgap_sel, port_b_bit_one_sel,
           port_b_bit_zero_sel},
          {codes[i], codes[i] < `ACC_CH_PINS, codes[i] == `ACC_CH_BGAP,
           codes[i] == `ACC_CH_PORT_B_BIT_ONE,
           codes[i] == `ACC_CH_PORT_B_BIT_ZERO});
    end
    for (int i = 0; i < 14; i++)
    begin
      lfsr = lfsr_next(lfsr);
      m10 = lfsr[2];
      vin <= lfsr[12:3];
      axi_wr(`ACC_OFS_CLK, {27'h0, lfsr[1], m10, 3'h0});
      convert(lfsr[5] ? `ACC_CH_PORT_B_BIT_ZERO : `ACC_CH_PORT_B_BIT_ONE, t0);
      chk(res, exp_res(vin, m10));
    end
    axi_wr(`ACC_OFS_CLK, 32'h00000008);
    convert(`ACC_CH_BGAP, t0);
    chk(res, 10'h1C3);
    axi_wr(`ACC_OFS_CLK, 32'h00000018);
    convert(`ACC_CH_BGAP, t1);
    chk(t1 > t0, 1'b1);
    // Divider of two, then continuous conversion on the bandgap
    axi_wr(`ACC_OFS_CLK, 32'h00000028);
    convert(`ACC_CH_BGAP, t1);
    chk(res, 10'h1C3);
    chk(t1 > t0, 1'b1);
    cont_bit = 1'b1;
    convert(`ACC_CH_BGAP, t1);
    cont_bit = 1'b0;
    chk(res, 10'h1C3);
    axi_rd(`ACC_OFS_SCR, rd);
    chk(rd, 32'h000000BA);
    axi_wr(`ACC_OFS_SCR, {27'h0, `ACC_CH_OFF});
    stop_mode <= 1'b1;
    axi_wr(`ACC_OFS_CLK, 32'h00000008);
    axi_wr(`ACC_OFS_SCR, {27'h0, `ACC_CH_PORT_B_BIT_ZERO});
    repeat (100) @(posedge aclk);
    axi_rd(`ACC_OFS_SCR, rd);
    chk(rd[`ACC_SCR_DONE], 1'b0);
    axi_wr(`ACC_OFS_CLK, 32'h0000000C);
    convert(`ACC_CH_PORT_B_BIT_ZERO, t1);
    chk(res, vin);
    chk(t1 > t0, 1'b1);
    stop_mode <= 1'b0;
    summarize();
  end
endmodule : tb_adc_control_and_clocking
